// ### common/lcd_cmd_pkg.sv
package lcd_cmd_pkg;

    // ****************************************************************
    // Register map (byte addresses, one aligned word each)
    // ****************************************************************
    localparam logic [7:0] ADR_CMD      = 8'h00;
    localparam logic [7:0] ADR_STATUS   = 8'h04;
    localparam logic [7:0] ADR_RESP     = 8'h08;
    localparam logic [7:0] ADR_REPMASK  = 8'h0c;
    localparam logic [7:0] ADR_REPPEND  = 8'h10;
    localparam logic [7:0] ADR_ENUM     = 8'h14;
    localparam logic [7:0] ADR_SETTINGS = 8'h18;
    localparam logic [1:0] ADR_DATA_HI  = 2'h1;  // 0x40..0x7c data window

    // Field positions
    localparam int CMD_LEN_LSB  = 8;   // CMD/RESP: [7:0] type, [12:8] length
    localparam int ENUM_BYTE_LSB = 8;  // ENUM: [7:0] value, [10:8] byte
    localparam int ENUM_IDX_LSB = 16;  // ENUM: [20:16] index
    localparam int ENUM_DONE_BIT = 31; // ENUM: enumeration finished

    // ****************************************************************
    // Command and response codes
    // ****************************************************************
    localparam logic [7:0] CMD_LINE1    = 8'h07;
    localparam logic [7:0] CMD_LINE2    = 8'h08;
    localparam logic [7:0] CMD_GLYPH    = 8'h09;
    localparam logic [7:0] CMD_MEMREAD  = 8'h0a;
    localparam logic [7:0] CMD_CURPOS   = 8'h0b;
    localparam logic [7:0] CMD_CURSTYLE = 8'h0c;
    localparam logic [7:0] CMD_CONTRAST = 8'h0d;
    localparam logic [7:0] CMD_BACKLT   = 8'h0e;
    localparam logic [7:0] CMD_DEVINFO  = 8'h12;
    localparam logic [7:0] CMD_REPSETUP = 8'h13;
    localparam logic [1:0] RESP_OK      = 2'h1;  // Type bits [7:6], 0x40
    localparam logic [1:0] RESP_ERR     = 2'h3;  // Type bits [7:6], 0xc0

    // Limits
    localparam logic [4:0] LINE_LEN      = 5'h10;
    localparam logic [7:0] GLYPH_MAX     = 8'h07;
    localparam logic [7:0] GLYPH_ROW_MAX = 8'h3f;
    localparam logic [7:0] COL_MAX       = 8'h0f;
    localparam logic [7:0] ROW_MAX       = 8'h01;
    localparam logic [7:0] STYLE_MAX     = 8'h03;
    localparam logic [7:0] CONTRAST_MAX  = 8'hc8;
    localparam logic [7:0] DEV_IDX_MAX   = 8'h1f;

    // Reset values
    localparam logic [7:0] CONTRAST_RST = 8'h10;
    localparam logic [7:0] BACKLT_RST   = 8'h64;
    localparam logic [7:0] BLANK_CHAR   = 8'h20;

    // ****************************************************************
    // Timing: report period of one second at 100 MHz
    // ****************************************************************
    localparam int REPORT_PERIOD_MS = 1000;
    localparam int CLK_FREQ_KHZ     = 100000;
    localparam int REPORT_CYCLES    = REPORT_PERIOD_MS * CLK_FREQ_KHZ;

endpackage : lcd_cmd_pkg

// ### verilog/lcd_cmd_handler.sv
// Summary of operation
// - Reply type keeps low six command bits; normal reply adds 0x40.
// - Line-one command, sixteen bytes, fills upper row; reply 0x47.
// - Line-two command, sixteen bytes, fills lower row; empty reply 0x48.
// - Glyph command: slot 0-7 then eight rows into glyph RAM; reply 0x49.
// - Glyph rows 0-63, MSB leftmost, first byte is the top row.
// - Memory read replies address code then eight memory bytes.
// - Cursor command: column 0-15, row 0-1; empty reply 0x4b.
// - Cursor style picks one of four looks; empty reply 0x4c.
// - One-byte contrast takes 0-200 legacy value and is acknowledged.
// - Two-byte contrast ignores first byte, sets contrast from second.
// - One-byte backlight sets display and keypad backlight alike.
// - Two-byte backlight: first byte display, second byte keypad.
// - Text, glyphs, cursor, contrast, backlights held as saveable state.
// - Bus identities recorded at power-up answer later queries.
// - Device query index 0-31 returns index plus eight-byte identifier.
// - First identifier byte is the bus device family code.
// - Only the two sensor families may report temperature.
// - Report setup: four-byte mask, bit n of byte k is 8k+n.
// - Each enabled sensor raises a report once every second.
//
// The register addresses and register access over Wishbone were left to the implementer.
`timescale 1ns/1ps
module lcd_cmd_handler
    import lcd_cmd_pkg::*;
#(
    parameter int        REPORT_PERIOD = REPORT_CYCLES,
    parameter logic [7:0] FAMILY_A     = 8'h3a, // Arbitrary value
    parameter logic [7:0] FAMILY_B     = 8'h5c  // Arbitrary value
) (
    input  wire logic        CLK,
    input  wire logic        RESETN,
    input  wire logic        WB_CYC_I,
    input  wire logic        WB_STB_I,
    input  wire logic        WB_WE_I,
    input  wire logic [7:0]  WB_ADR_I,
    input  wire logic [3:0]  WB_SEL_I,
    input  wire logic [31:0] WB_DAT_I,
    output logic      [31:0] WB_DAT_O,
    output logic             WB_ACK_O,
    output logic      [7:0]  CONTRAST,
    output logic      [7:0]  LCD_BACKLIGHT,
    output logic      [7:0]  KEY_BACKLIGHT,
    output logic      [3:0]  CURSOR_COL,
    output logic             CURSOR_ROW,
    output logic      [1:0]  CURSOR_STYLE
);

    typedef enum logic {ST_IDLE, ST_EXEC} exec_state_t;

    // ****************************************************************
    // State declarations
    // ****************************************************************
    logic [31:0] dat_r,      dat_nxt;
    logic        ack_r,      ack_nxt;
    logic        start_r,    start_nxt;
    logic [7:0]  cmd_type_r, cmd_type_nxt;
    logic [4:0]  cmd_len_r,  cmd_len_nxt;
    logic [7:0]  cmd_d_r     [16];
    logic [7:0]  cmd_d_nxt   [16];
    logic [63:0] id_r        [32];
    logic [63:0] id_nxt      [32];
    logic [31:0] present_r,  present_nxt;
    logic        enum_done_r, enum_done_nxt;
    logic [31:0] pend_clr;

    exec_state_t state_r,    state_nxt;
    logic [7:0]  disp_r      [32];
    logic [7:0]  disp_nxt    [32];
    logic [5:0]  glyph_r     [64];
    logic [5:0]  glyph_nxt   [64];
    logic [7:0]  resp_d_r    [9];
    logic [7:0]  resp_d_nxt  [9];
    logic [7:0]  resp_type_r, resp_type_nxt;
    logic [4:0]  resp_len_r, resp_len_nxt;
    logic        resp_vld_r, resp_vld_nxt;
    logic [7:0]  contrast_r, contrast_nxt;
    logic [7:0]  lcd_bl_r,   lcd_bl_nxt;
    logic [7:0]  key_bl_r,   key_bl_nxt;
    logic [3:0]  col_r,      col_nxt;
    logic        row_r,      row_nxt;
    logic [1:0]  style_r,    style_nxt;
    logic [31:0] rep_mask_r, rep_mask_nxt;
    logic        cmd_ok;

    logic [31:0] tick_cnt_r, tick_cnt_nxt;
    logic        tick_r,     tick_nxt;
    logic [31:0] rep_pend_r, rep_pend_nxt;
    logic [31:0] eligible;

    logic        bus_req;
    logic        busy;
    assign bus_req = WB_CYC_I && WB_STB_I && !ack_r;
    assign busy    = start_r || (state_r != ST_IDLE);

    // ****************************************************************
    // Wishbone slave: one wait state, ack for one cycle
    // ****************************************************************

    // Decode, data window and identity table loading
    always_comb begin
        int          d_idx;
        logic [4:0]  e_idx;
        logic [2:0]  e_byte;
        d_idx        = int'(WB_ADR_I[5:2]);
        e_idx        = WB_DAT_I[ENUM_IDX_LSB +: 5];
        e_byte       = WB_DAT_I[ENUM_BYTE_LSB +: 3];
        ack_nxt      = bus_req;
        dat_nxt      = dat_r;
        start_nxt    = 1'b0;
        cmd_type_nxt = cmd_type_r;
        cmd_len_nxt  = cmd_len_r;
        cmd_d_nxt    = cmd_d_r;
        id_nxt       = id_r;
        present_nxt  = present_r;
        enum_done_nxt = enum_done_r;
        pend_clr     = 32'h0;
        if (bus_req && WB_WE_I && WB_SEL_I[0]) begin
            // A new command is refused while one is still in progress
            if (WB_ADR_I == ADR_CMD && !busy) begin
                cmd_type_nxt = WB_DAT_I[7:0];
                cmd_len_nxt  = WB_DAT_I[CMD_LEN_LSB +: 5];
                start_nxt    = 1'b1;
            end
            if (WB_ADR_I[7:6] == ADR_DATA_HI && !busy) begin
                cmd_d_nxt[d_idx] = WB_DAT_I[7:0];
            end
            if (WB_ADR_I == ADR_REPPEND) begin
                pend_clr = WB_DAT_I;
            end
            if (WB_ADR_I == ADR_ENUM && !enum_done_r) begin
                id_nxt[e_idx][8*e_byte +: 8] = WB_DAT_I[7:0];
                present_nxt[e_idx] = 1'b1;
                enum_done_nxt = WB_DAT_I[ENUM_DONE_BIT];
            end
        end
        if (bus_req && !WB_WE_I) begin
            dat_nxt = 32'h0;
            case (WB_ADR_I)
                ADR_CMD:     dat_nxt = {19'h0, cmd_len_r, cmd_type_r};
                ADR_STATUS:  dat_nxt = {29'h0, enum_done_r, resp_vld_r,
                                        busy};
                ADR_RESP:    dat_nxt = {19'h0, resp_len_r, resp_type_r};
                ADR_REPMASK: dat_nxt = rep_mask_r;
                ADR_REPPEND: dat_nxt = rep_pend_r;
                ADR_ENUM:    dat_nxt = present_r;
                ADR_SETTINGS: dat_nxt = {style_r, row_r, 1'b0, col_r,
                                         key_bl_r, lcd_bl_r, contrast_r};
                default: begin
                    if (WB_ADR_I[7:6] == ADR_DATA_HI && d_idx < 9) begin
                        dat_nxt = {24'h0, resp_d_r[d_idx]};
                    end
                end
            endcase
        end
    end

    // Bus group registers
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            dat_r       <= 32'h0;
            ack_r       <= 1'b0;
            start_r     <= 1'b0;
            cmd_type_r  <= 8'h0;
            cmd_len_r   <= 5'h0;
            cmd_d_r     <= '{default: 8'h0};
            id_r        <= '{default: 64'h0};
            present_r   <= 32'h0;
            enum_done_r <= 1'b0;
        end else begin
            dat_r       <= dat_nxt;
            ack_r       <= ack_nxt;
            start_r     <= start_nxt;
            cmd_type_r  <= cmd_type_nxt;
            cmd_len_r   <= cmd_len_nxt;
            cmd_d_r     <= cmd_d_nxt;
            id_r        <= id_nxt;
            present_r   <= present_nxt;
            enum_done_r <= enum_done_nxt;
        end
    end

    // ****************************************************************
    // Command execution
    // ****************************************************************

    // Every command is checked in full before anything changes, so a
    // rejected packet leaves every setting as it was
    always_comb begin
        logic [7:0] a;
        logic [5:0] g_idx;
        logic [4:0] d_base;
        logic       rows_ok;
        a             = cmd_d_r[0];
        g_idx         = 6'h0;
        d_base        = 5'h0;
        rows_ok       = 1'b1;
        cmd_ok        = 1'b0;
        state_nxt     = state_r;
        disp_nxt      = disp_r;
        glyph_nxt     = glyph_r;
        resp_d_nxt    = resp_d_r;
        resp_type_nxt = resp_type_r;
        resp_len_nxt  = resp_len_r;
        resp_vld_nxt  = resp_vld_r;
        contrast_nxt  = contrast_r;
        lcd_bl_nxt    = lcd_bl_r;
        key_bl_nxt    = key_bl_r;
        col_nxt       = col_r;
        row_nxt       = row_r;
        style_nxt     = style_r;
        rep_mask_nxt  = rep_mask_r;
        for (int i = 1; i < 9; i++) begin
            if (cmd_d_r[i] > GLYPH_ROW_MAX) rows_ok = 1'b0;
        end
        case (state_r)
            ST_IDLE: begin
                if (start_r) begin
                    state_nxt    = ST_EXEC;
                    resp_vld_nxt = 1'b0;
                end
            end
            ST_EXEC: begin
                state_nxt    = ST_IDLE;
                resp_vld_nxt = 1'b1;
                resp_len_nxt = 5'h0;
                case (cmd_type_r)
                    CMD_LINE1, CMD_LINE2: begin
                        if (cmd_len_r == LINE_LEN) begin
                            cmd_ok = 1'b1;
                            for (int i = 0; i < 16; i++) begin
                                disp_nxt[{cmd_type_r == CMD_LINE2,
                                          4'(i)}] = cmd_d_r[i];
                            end
                        end
                    end
                    CMD_GLYPH: begin
                        if (cmd_len_r == 5'h9 && a <= GLYPH_MAX && rows_ok)
                        begin
                            cmd_ok = 1'b1;
                            for (int i = 0; i < 8; i++) begin
                                glyph_nxt[{a[2:0], 3'(i)}] =
                                    cmd_d_r[i + 1][5:0];
                            end
                        end
                    end
                    // memory read, bit 7 of the code picks glyph RAM
                    CMD_MEMREAD: begin
                        if (cmd_len_r == 5'h1) begin
                            cmd_ok        = 1'b1;
                            resp_len_nxt  = 5'h9;
                            resp_d_nxt[0] = a;
                            for (int i = 0; i < 8; i++) begin
                                g_idx  = a[5:0] + 6'(i);
                                d_base = a[4:0] + 5'(i);
                                resp_d_nxt[i + 1] = a[7] ?
                                    {2'h0, glyph_r[g_idx]} : disp_r[d_base];
                            end
                        end
                    end
                    CMD_CURPOS: begin
                        if (cmd_len_r == 5'h2 && a <= COL_MAX &&
                            cmd_d_r[1] <= ROW_MAX) begin
                            cmd_ok  = 1'b1;
                            col_nxt = a[3:0];
                            row_nxt = cmd_d_r[1][0];
                        end
                    end
                    CMD_CURSTYLE: begin
                        if (cmd_len_r == 5'h1 && a <= STYLE_MAX) begin
                            cmd_ok    = 1'b1;
                            style_nxt = a[1:0];
                        end
                    end
                    CMD_CONTRAST: begin
                        if (cmd_len_r == 5'h1 && a <= CONTRAST_MAX) begin
                            cmd_ok       = 1'b1;
                            contrast_nxt = a;
                        end else if (cmd_len_r == 5'h2) begin
                            cmd_ok       = 1'b1;
                            contrast_nxt = cmd_d_r[1];
                        end
                    end
                    CMD_BACKLT: begin
                        if (cmd_len_r == 5'h1) begin
                            cmd_ok     = 1'b1;
                            lcd_bl_nxt = a;
                            key_bl_nxt = a;
                        end else if (cmd_len_r == 5'h2) begin
                            cmd_ok     = 1'b1;
                            lcd_bl_nxt = a;
                            key_bl_nxt = cmd_d_r[1];
                        end
                    end
                    CMD_DEVINFO: begin
                        if (cmd_len_r == 5'h1 && a <= DEV_IDX_MAX) begin
                            cmd_ok        = 1'b1;
                            resp_len_nxt  = 5'h9;
                            resp_d_nxt[0] = a;
                            for (int i = 0; i < 8; i++) begin
                                resp_d_nxt[i + 1] = id_r[a[4:0]][8*i +: 8];
                            end
                        end
                    end
                    // four mask bytes, byte k covers 8k..8k+7
                    CMD_REPSETUP: begin
                        if (cmd_len_r == 5'h4) begin
                            cmd_ok       = 1'b1;
                            rep_mask_nxt = {cmd_d_r[3], cmd_d_r[2],
                                            cmd_d_r[1], cmd_d_r[0]};
                        end
                    end
                    default: cmd_ok = 1'b0;
                endcase
                resp_type_nxt = {cmd_ok ? RESP_OK : RESP_ERR,
                                 cmd_type_r[5:0]};
                if (!cmd_ok) resp_len_nxt = 5'h0;
            end
            default: state_nxt = ST_IDLE;
        endcase
    end

    // held settings, the set a boot-state store would capture
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            state_r     <= ST_IDLE;
            disp_r      <= '{default: BLANK_CHAR};
            glyph_r     <= '{default: 6'h0};
            resp_d_r    <= '{default: 8'h0};
            resp_type_r <= 8'h0;
            resp_len_r  <= 5'h0;
            resp_vld_r  <= 1'b0;
            contrast_r  <= CONTRAST_RST;
            lcd_bl_r    <= BACKLT_RST;
            key_bl_r    <= BACKLT_RST;
            col_r       <= 4'h0;
            row_r       <= 1'b0;
            style_r     <= 2'h0;
            rep_mask_r  <= 32'h0;
        end else begin
            state_r     <= state_nxt;
            disp_r      <= disp_nxt;
            glyph_r     <= glyph_nxt;
            resp_d_r    <= resp_d_nxt;
            resp_type_r <= resp_type_nxt;
            resp_len_r  <= resp_len_nxt;
            resp_vld_r  <= resp_vld_nxt;
            contrast_r  <= contrast_nxt;
            lcd_bl_r    <= lcd_bl_nxt;
            key_bl_r    <= key_bl_nxt;
            col_r       <= col_nxt;
            row_r       <= row_nxt;
            style_r     <= style_nxt;
            rep_mask_r  <= rep_mask_nxt;
        end
    end

    // ****************************************************************
    // Temperature reporting
    // ****************************************************************

    // only recorded sensors of the two families qualify
    for (genvar g = 0; g < 32; g++) begin : g_elig
        assign eligible[g] = present_r[g] &&
            (id_r[g][7:0] == FAMILY_A || id_r[g][7:0] == FAMILY_B);
    end

    // One-second tick; a new report wins over a clear in the same cycle
    always_comb begin
        tick_nxt     = 1'b0;
        tick_cnt_nxt = tick_cnt_r + 32'h1;
        if (tick_cnt_r == 32'(REPORT_PERIOD - 1)) begin
            tick_cnt_nxt = 32'h0;
            tick_nxt     = 1'b1;
        end
        // mask is also filtered by eligibility
        rep_pend_nxt = (rep_pend_r & ~pend_clr) |
                       (tick_r ? (rep_mask_r & eligible) : 32'h0);
    end

    // Report group registers
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            tick_cnt_r <= 32'h0;
            tick_r     <= 1'b0;
            rep_pend_r <= 32'h0;
        end else begin
            tick_cnt_r <= tick_cnt_nxt;
            tick_r     <= tick_nxt;
            rep_pend_r <= rep_pend_nxt;
        end
    end

    // Outputs straight from flip-flops
    assign WB_DAT_O      = dat_r;
    assign WB_ACK_O      = ack_r;
    assign CONTRAST      = contrast_r;
    assign LCD_BACKLIGHT = lcd_bl_r;
    assign KEY_BACKLIGHT = key_bl_r;
    assign CURSOR_COL    = col_r;
    assign CURSOR_ROW    = row_r;
    assign CURSOR_STYLE  = style_r;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESETN);

    ack_one_cycle_a: assert property (
        WB_ACK_O |=> !WB_ACK_O) else $error("ack held too long");
    reply_type_a: assert property (
        state_r == ST_EXEC |=> resp_type_r[5:0] == $past(cmd_type_r[5:0])
        && resp_vld_r) else $error("reply type mismatch");
    top_row_a: assert property (
        state_r == ST_EXEC && cmd_type_r == CMD_LINE1 && cmd_len_r == 5'h10
        |=> disp_r[0] == $past(cmd_d_r[0]) && disp_r[15] ==
        $past(cmd_d_r[15]) && resp_type_r == 8'h47)
        else $error("upper row not written");
    cursor_move_a: assert property (
        state_r == ST_EXEC && cmd_ok && cmd_type_r == CMD_CURPOS
        |=> CURSOR_COL == $past(cmd_d_r[0][3:0]) &&
        CURSOR_ROW == $past(cmd_d_r[1][0])) else $error("cursor not moved");
    fine_contrast_a: assert property (
        state_r == ST_EXEC && cmd_type_r == CMD_CONTRAST && cmd_len_r == 5'h2
        |=> CONTRAST == $past(cmd_d_r[1])) else $error("fine contrast");
    shared_backlight_a: assert property (
        state_r == ST_EXEC && cmd_type_r == CMD_BACKLT && cmd_len_r == 5'h1
        |=> LCD_BACKLIGHT == KEY_BACKLIGHT) else $error("backlights differ");
    reject_keeps_a: assert property (
        state_r == ST_EXEC && !cmd_ok |=> resp_type_r[7:6] == RESP_ERR &&
        $stable(CONTRAST) && $stable(CURSOR_COL) && $stable(rep_mask_r))
        else $error("rejected command changed state");
    report_tick_a: assert property (
        tick_r |=> (rep_pend_r & $past(rep_mask_r & eligible)) ==
        $past(rep_mask_r & eligible)) else $error("report not raised");
    report_elig_a: assert property (
        tick_r && !eligible[0] && !rep_pend_r[0] |=> !rep_pend_r[0])
        else $error("ineligible sensor reported");

endmodule : lcd_cmd_handler

// ### bench/wb_host.sv
`timescale 1ns/1ps
module wb_host (
    input  wire logic        clk,
    input  wire logic        ack,
    input  wire logic [31:0] rdat,
    output logic             cyc,
    output logic             we,
    output logic [7:0]       adr,
    output logic [31:0]      wdat
);
    // Idle bus at time zero
    initial begin
        cyc  = 1'b0;
        we   = 1'b0;
        adr  = 8'h00;
        wdat = 32'h0;
    end
    // One classic cycle: request held until ack, released at that edge
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] d, output logic [31:0] q);
        @(posedge clk);
        cyc  <= 1'b1;
        we   <= w;
        adr  <= a;
        wdat <= d;
        // Ack and read data are taken at one rising edge; the bench
        // timeout is the only limit on the wait
        do begin
            @(posedge clk);
        end while (ack !== 1'b1);
        q = rdat;
        cyc  <= 1'b0;
        // Inverted so stale data never looks valid
        wdat <= ~d;
    endtask : xfer
endmodule : wb_host

// ### bench/tb.sv
`timescale 1ns/1ps
module tb;
    import lcd_cmd_pkg::*;
    logic        clk, rst_n, cyc, we, ack;
    logic [7:0]  adr;
    logic [31:0] wdat, rdat, q;
    logic [7:0]  d [16];
    int          error_cnt, tests_run, cyc_cnt;
    // Output pins packed in the layout of the settings word
    wire  [31:0] pins;
    assign pins[28] = 1'b0;
    // Clock and hang guard
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc_cnt <= cyc_cnt + 1;
        if (cyc_cnt == 20000) begin
            error_cnt++;
            end_sim();
        end
    end
    wb_host host (.clk(clk), .ack(ack), .rdat(rdat), .cyc(cyc), .we(we),
                  .adr(adr), .wdat(wdat));
    // Sensor family codes are arbitrary stand-ins
    lcd_cmd_handler #(.REPORT_PERIOD(20), .FAMILY_A(8'h3a),
        .FAMILY_B(8'h5c)) dut (.CLK(clk), .RESETN(rst_n),
        .WB_CYC_I(cyc), .WB_STB_I(cyc), .WB_WE_I(we), .WB_ADR_I(adr),
        .WB_SEL_I(4'hf), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
        .CONTRAST(pins[7:0]), .LCD_BACKLIGHT(pins[15:8]),
        .KEY_BACKLIGHT(pins[23:16]), .CURSOR_COL(pins[27:24]),
        .CURSOR_ROW(pins[29]), .CURSOR_STYLE(pins[31:30]));
    task automatic chk(input string s, input logic [31:0] e, g);
        tests_run++;
        if (g !== e) begin
            error_cnt++;
            $display("[ERR] %s exp %h got %h", s, e, g);
        end
    endtask : chk
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        host.xfer(1'b0, a, 32'h0, q);
        chk($sformatf("rd %h", a), e, q);
        // The output pins must agree with the settings word
        if (a == ADR_SETTINGS)
            chk("pins", e, pins);
    endtask : rd
    // Load data, start, poll for reply, check reply word
    task automatic cmd(input logic [7:0] t, input logic [4:0] n,
                       input logic ok, input logic [4:0] rl);
        for (int i = 0; i < n; i++)
            host.xfer(1'b1, 8'h40 + 8'(4 * i), {24'h0, d[i]}, q);
        host.xfer(1'b1, ADR_CMD, {19'h0, n, t}, q);
        for (int i = 0; i < 20; i++) begin
            host.xfer(1'b0, ADR_STATUS, 32'h0, q);
            if (q[1] === 1'b1)
                break;
        end
        rd(ADR_RESP, {19'h0, rl, ok ? RESP_OK : RESP_ERR, t[5:0]});
    endtask : cmd
    task automatic end_sim();
        $display("checks %0d errors %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : end_sim
    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        rst_n = 1'b0;
        error_cnt = 0;
        tests_run = 0;
        cyc_cnt = 0;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        rd(ADR_SETTINGS, 32'h00646410);
        d[0] = 8'h0f;
        d[1] = 8'h01;
        cmd(CMD_CURPOS, 2, 1, 0);
        d[0] = 8'h10;
        cmd(CMD_CURPOS, 2, 0, 0);
        d[0] = 8'h03;
        cmd(CMD_CURSTYLE, 1, 1, 0);
        rd(ADR_SETTINGS, 32'hef646410);
        d[0] = 8'hff;
        d[1] = 8'h21;
        cmd(CMD_CONTRAST, 2, 1, 0);
        rd(ADR_SETTINGS, 32'hef646421);
        d[0] = 8'hc9;
        cmd(CMD_CONTRAST, 1, 0, 0);
        d[0] = 8'hc8;
        cmd(CMD_CONTRAST, 1, 1, 0);
        d[0] = 8'h33;
        cmd(CMD_BACKLT, 1, 1, 0);
        rd(ADR_SETTINGS, 32'hef3333c8);
        d[0] = 8'h11;
        d[1] = 8'h22;
        cmd(CMD_BACKLT, 2, 1, 0);
        rd(ADR_SETTINGS, 32'hef2211c8);
        for (int i = 0; i < 16; i++)
            d[i] = 8'h41 + 8'(i);
        cmd(CMD_LINE1, 15, 0, 0);
        cmd(CMD_LINE1, 16, 1, 0);
        // A distinct first byte tells the two rows apart
        d[0] = 8'h61;
        cmd(CMD_LINE2, 16, 1, 0);
        cmd(CMD_GLYPH, 9, 0, 0);
        // Read across the row boundary: end of row 0, start of row 1
        d[0] = 8'h0f;
        cmd(CMD_MEMREAD, 1, 1, 9);
        rd(8'h40, 32'h0f);
        rd(8'h44, 32'h50);
        rd(8'h48, 32'h61);
        rd(8'h60, 32'h47);
        // Slot 5, rows 0x31..0x38 from top to bottom
        d[0] = 8'h05;
        for (int i = 1; i < 9; i++)
            d[i] = 8'h30 + 8'(i);
        cmd(CMD_GLYPH, 9, 1, 0);
        // A row above 63 is refused and leaves the slot alone
        d[8] = 8'h40;
        cmd(CMD_GLYPH, 9, 0, 0);
        d[0] = 8'ha8;
        cmd(CMD_MEMREAD, 1, 1, 9);
        rd(8'h44, 32'h31);
        rd(8'h60, 32'h38);
        // Enumeration record: index 3 holds a sensor family code
        host.xfer(1'b1, ADR_ENUM, {11'h0, 5'd3, 8'h0, 8'h3a}, q);
        d[0] = 8'h03;
        cmd(CMD_DEVINFO, 1, 1, 9);
        rd(8'h40, 32'h03);
        rd(8'h44, 32'h3a);
        // Mask bits 9, 18, 31 name absent devices and must stay silent
        d[0] = 8'h08;
        d[1] = 8'h02;
        d[2] = 8'h04;
        d[3] = 8'h80;
        cmd(CMD_REPSETUP, 4, 1, 0);
        rd(ADR_REPMASK, 32'h80040208);
        repeat (50) @(posedge clk);
        rd(ADR_REPPEND, 32'h8);
        // With the mask emptied, writing a one clears the pending bit
        for (int i = 0; i < 4; i++)
            d[i] = 8'h00;
        cmd(CMD_REPSETUP, 4, 1, 0);
        host.xfer(1'b1, ADR_REPPEND, 32'h8, q);
        rd(ADR_REPPEND, 32'h0);
        end_sim();
    end
endmodule : tb
